// file: design/flash_cmd_regs.svh
/*
 * Constants of the register command unit: instruction codes, status and
 * configuration bit positions, boot register field layout, frame lengths
 * and the self-timed update duration.
 * Assumes a 20 MHz system clock and 4-byte ECC unit addresses.
 */
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

`define INSTR_LATCH_SET 8'h06
`define INSTR_LATCH_CLEAR 8'h04
`define INSTR_CLEAR_STATUS 8'h30
`define INSTR_ECC_READ 8'h18
`define INSTR_BOOT_REG_READ 8'h14
`define INSTR_BOOT_REG_WRITE 8'h15
`define INSTR_NV_PATTERN 8'h43
`define INSTR_VOL_PATTERN 8'h4A

`define SR1_WIP_BIT 0
`define SR1_WEL_BIT 1
`define SR1_E_FAIL_BIT 5
`define SR1_P_FAIL_BIT 6
`define CR1_QUAD_BIT 1

`define BOOT_EN_BIT 0
`define BOOT_DELAY_LSB 1
`define BOOT_DELAY_MSB 8
`define BOOT_ADDR_LSB 9
`define BOOT_ADDR_MSB 31
`define BOOT_CFG_RESET 32'h0000_0000

`define BITS_INSTR_ONLY 6'h08
`define BITS_ONE_BYTE 6'h10
`define BITS_FOUR_BYTES 6'h28
`define ECC_HDR_BITS 9'h030
`define BOOT_READ_HDR_BITS 9'h008

`define UPDATE_TIME_US 100
`define SYS_CLK_MHZ 20

`endif

// file: design/flash_cmd_pkg.sv
/*
 * Types shared by the register command unit.
 * Assumes the constants header is included by the files that use it.
 */
package flash_cmd_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BOOT_UPDATE = 3'b010,
		ST_PATTERN_PROG = 3'b100
	} update_state_type;

	typedef struct packed {
		logic [7:0] instr;
		logic [31:0] data;
		logic [5:0] bits;
	} cmd_frame_type;

endpackage

// file: design/flash_register_command_unit.sv
/*
 * Register command unit of a serial flash: latch set and clear, status
 * error clear, ECC status read, boot-on-reset read and its configuration
 * register, learning-pattern program and write.
 * Assumes SPI mode 0 on link_sck, a memory array and ECC engine that answer
 * a byte for the address they are given within the same link cycle, and a
 * chip-select high time of at least four sys_clk periods.
 */
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"

// Behaviour
// - Write-disable instruction clears the write enable latch.
// - Write-disable is ignored while write-in-progress is one.
// - Write-disable acts only if chip select rises after exactly eight bits.
// - Clear-status resets the erase fail and program fail flags.
// - Clear-status needs no write enable latch and leaves it unchanged.
// - Clear-status is accepted even while write-in-progress is one.
// - ECC read takes a 32-bit unit address, then eight dummy clocks.
// - ECC status byte repeats sixteen times per unit, then next unit follows.
// - With boot enabled, reset arms a read from the start address.
// - Boot data is held back by the 8-bit start delay count.
// - Boot start address is a 23-bit field of 512-byte blocks.
// - Boot streams until chip select rises, then never again until reset.
// - Boot delivers four bits per clock when the quad bit is set.
// - Boot register read sends low byte first, repeating every 32 clocks.
// - Boot register write needs the write enable latch set.
// - Boot register write takes 32 bits, chip select rising right after.
// - Boot register update runs self-timed, flags failures, clears the latch.
// - Pattern program needs the latch and one byte ending the frame.
// - Pattern program runs self-timed, flags failure, clears the latch.
// - Volatile pattern write needs the latch and one byte, loads at once.
// - Write-enable instruction sets the write enable latch.
module flash_register_command_unit #(
	parameter int UPDATE_CYCLES = `UPDATE_TIME_US * `SYS_CLK_MHZ,
	parameter logic [31:0] BOOT_CFG_INIT = `BOOT_CFG_RESET
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic link_sck,
	input wire logic cs_n,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic [3:0] dq_oe,
	input wire logic [7:0] config_reg_one,
	output logic [31:0] array_addr,
	input wire logic [7:0] array_data,
	output logic [31:0] ecc_unit_addr,
	input wire logic [7:0] ecc_status,
	input wire logic [1:0] update_fail,
	output logic [7:0] status_reg_one,
	output logic [31:0] boot_read_config,
	output logic [7:0] nv_pattern,
	output logic [7:0] vol_pattern
);

	// System domain state that the link side reads; it only changes while
	// chip select is high, so the link samples it as a static value.
	logic [31:0] boot_cfg_reg;
	logic boot_armed_reg;

	// Link domain
	logic frame_on_reg;
	logic frame_tgl_reg;
	logic [5:0] bit_cnt_reg;
	logic [7:0] instr_reg;
	logic [31:0] data_reg;
	logic [8:0] hdr_reg;
	logic [23:0] dat_reg;
	logic [5:0] bit_cur;
	logic [8:0] hdr_cur;
	logic [23:0] dat_cur;
	logic [8:0] hdr_len;
	logic read_mode;
	logic in_data;
	logic quad_mode;
	logic [22:0] byte_idx;
	logic [7:0] tx_byte;

	// Counters restart at each frame without needing an edge while cs_n is high
	assign bit_cur = frame_on_reg ? bit_cnt_reg : 6'h00;
	assign hdr_cur = frame_on_reg ? hdr_reg : 9'h000;
	assign dat_cur = frame_on_reg ? dat_reg : 24'h000000;

	always_ff @(posedge link_sck or posedge cs_n) begin
		if (cs_n) begin
			frame_on_reg <= 1'b0;
		end else begin
			frame_on_reg <= 1'b1;
		end
	end

	// One toggle per frame tells the system side that the captured frame is new
	always_ff @(posedge link_sck or posedge srst) begin
		if (srst) begin
			frame_tgl_reg <= 1'b0;
		end else if (!frame_on_reg) begin
			frame_tgl_reg <= ~frame_tgl_reg;
		end
	end

	always_ff @(posedge link_sck) begin
		bit_cnt_reg <= (bit_cur == 6'h3F) ? bit_cur : bit_cur + 6'h01;
	end

	// Shifting stops after 40 bits so the dummy clocks keep the ECC address
	always_ff @(posedge link_sck) begin
		if (bit_cur < `BITS_INSTR_ONLY) begin
			instr_reg <= {instr_reg[6:0], dq_in[0]};
		end else if (bit_cur < `BITS_FOUR_BYTES) begin
			data_reg <= {data_reg[30:0], dq_in[0]};
		end
	end

	always_comb begin
		hdr_len = 9'h1FF;
		read_mode = 1'b0;
		if (boot_armed_reg) begin
			hdr_len = {1'b0, boot_cfg_reg[`BOOT_DELAY_MSB:`BOOT_DELAY_LSB]};
			read_mode = 1'b1;
		end else if (bit_cur >= `BITS_INSTR_ONLY) begin
			case (instr_reg)
				`INSTR_BOOT_REG_READ: begin
					hdr_len = `BOOT_READ_HDR_BITS;
					read_mode = 1'b1;
				end
				`INSTR_ECC_READ: begin
					hdr_len = `ECC_HDR_BITS;
					read_mode = 1'b1;
				end
				default: begin
					hdr_len = 9'h1FF;
					read_mode = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_sck) begin
		if (hdr_cur != hdr_len) begin
			hdr_reg <= hdr_cur + 9'h001;
			dat_reg <= 24'h000000;
		end else begin
			hdr_reg <= hdr_cur;
			dat_reg <= dat_cur + 24'h000001;
		end
	end

	assign in_data = read_mode && !cs_n && (hdr_cur == hdr_len);
	assign quad_mode = boot_armed_reg && config_reg_one[`CR1_QUAD_BIT];
	assign byte_idx = quad_mode ? dat_cur[23:1] : {2'b00, dat_cur[23:3]};

	// The boot stream walks the array from the 512-byte aligned start
	assign array_addr = {boot_cfg_reg[`BOOT_ADDR_MSB:`BOOT_ADDR_LSB], 9'h000} + {9'h000, byte_idx};
	// Every sixteen bytes the ECC unit address steps to the next unit
	assign ecc_unit_addr = {data_reg[31:4], 4'h0} + {9'h000, byte_idx[22:4], 4'h0};

	always_comb begin
		if (boot_armed_reg) begin
			tx_byte = array_data;
		end else if (instr_reg == `INSTR_BOOT_REG_READ) begin
			tx_byte = boot_cfg_reg[{byte_idx[1:0], 3'b000} +: 8];
		end else begin
			tx_byte = ecc_status;
		end
	end

	always_comb begin
		if (!in_data) begin
			dq_out = 4'h0;
			dq_oe = 4'h0;
		end else if (quad_mode) begin
			dq_out = dat_cur[0] ? tx_byte[3:0] : tx_byte[7:4];
			dq_oe = 4'hF;
		end else begin
			dq_out = {2'b00, tx_byte[3'h7 - dat_cur[2:0]], 1'b0};
			dq_oe = 4'h2;
		end
	end

	// System domain
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_s3_reg;
	logic tgl_s1_reg;
	logic tgl_s2_reg;
	logic tgl_seen_reg;
	logic frame_end;
	logic fresh_end;
	logic cmd_end;
	flash_cmd_pkg::cmd_frame_type frame;
	flash_cmd_pkg::update_state_type state_reg;
	logic [15:0] timer_reg;
	logic [31:0] pend_data_reg;
	logic wel_reg;
	logic e_fail_reg;
	logic p_fail_reg;
	logic write_in_progress;
	logic do_wel_set;
	logic do_wel_clear;
	logic do_clr_status;
	logic do_boot_write;
	logic do_nv_prog;
	logic do_vol_write;
	logic update_done;
	logic [7:0] nv_pattern_reg;
	logic [7:0] vol_pattern_reg;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
		end else begin
			cs_s1_reg <= cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
			tgl_seen_reg <= 1'b0;
		end else begin
			tgl_s1_reg <= frame_tgl_reg;
			tgl_s2_reg <= tgl_s1_reg;
			if (frame_end) begin
				tgl_seen_reg <= tgl_s2_reg;
			end
		end
	end

	// Link registers are still while cs_n is high, so they are read as a word here
	assign frame = '{instr: instr_reg, data: data_reg, bits: bit_cnt_reg};
	assign frame_end = cs_s2_reg && !cs_s3_reg;
	assign fresh_end = frame_end && (tgl_s2_reg != tgl_seen_reg);
	assign cmd_end = fresh_end && !boot_armed_reg;

	// A set error flag keeps the part busy until software clears it
	assign write_in_progress = (state_reg != flash_cmd_pkg::ST_IDLE) || e_fail_reg || p_fail_reg;

	assign do_wel_set = cmd_end && frame.instr == `INSTR_LATCH_SET && frame.bits == `BITS_INSTR_ONLY;
	assign do_wel_clear = cmd_end && frame.instr == `INSTR_LATCH_CLEAR
		&& frame.bits == `BITS_INSTR_ONLY && !write_in_progress;
	assign do_clr_status = cmd_end && frame.instr == `INSTR_CLEAR_STATUS
		&& frame.bits == `BITS_INSTR_ONLY;
	assign do_boot_write = cmd_end && frame.instr == `INSTR_BOOT_REG_WRITE
		&& frame.bits == `BITS_FOUR_BYTES && wel_reg && !write_in_progress;
	assign do_nv_prog = cmd_end && frame.instr == `INSTR_NV_PATTERN
		&& frame.bits == `BITS_ONE_BYTE && wel_reg && !write_in_progress;
	assign do_vol_write = cmd_end && frame.instr == `INSTR_VOL_PATTERN
		&& frame.bits == `BITS_ONE_BYTE && wel_reg && !write_in_progress;

	// Results land only while cs_n is high, keeping link-visible state static
	assign update_done = (state_reg != flash_cmd_pkg::ST_IDLE) && timer_reg == 16'h0000 && cs_s2_reg;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= flash_cmd_pkg::ST_IDLE;
			timer_reg <= 16'h0000;
		end else begin
			case (state_reg)
				flash_cmd_pkg::ST_IDLE: begin
					timer_reg <= 16'(UPDATE_CYCLES - 1);
					if (do_boot_write) begin
						state_reg <= flash_cmd_pkg::ST_BOOT_UPDATE;
					end else if (do_nv_prog) begin
						state_reg <= flash_cmd_pkg::ST_PATTERN_PROG;
					end
				end
				flash_cmd_pkg::ST_BOOT_UPDATE, flash_cmd_pkg::ST_PATTERN_PROG: begin
					if (timer_reg != 16'h0000) begin
						timer_reg <= timer_reg - 16'h0001;
					end else if (update_done) begin
						state_reg <= flash_cmd_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= flash_cmd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pend_data_reg <= 32'h0000_0000;
		end else if (do_boot_write || do_nv_prog) begin
			pend_data_reg <= frame.data;
		end
	end

	// A latch set arriving with a completion wins over the clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wel_reg <= 1'b0;
		end else if (do_wel_set) begin
			wel_reg <= 1'b1;
		end else if (do_wel_clear || update_done) begin
			wel_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			e_fail_reg <= 1'b0;
			p_fail_reg <= 1'b0;
		end else begin
			if (do_clr_status) begin
				e_fail_reg <= 1'b0;
				p_fail_reg <= 1'b0;
			end
			if (update_done && state_reg == flash_cmd_pkg::ST_BOOT_UPDATE && update_fail[1]) begin
				e_fail_reg <= 1'b1;
			end
			if (update_done && update_fail[0]) begin
				p_fail_reg <= 1'b1;
			end
		end
	end

	// Data arrives low byte first, each byte MSB first
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			boot_cfg_reg <= BOOT_CFG_INIT;
		end else if (update_done && state_reg == flash_cmd_pkg::ST_BOOT_UPDATE && update_fail == 2'b00) begin
			boot_cfg_reg <= {pend_data_reg[7:0], pend_data_reg[15:8],
				pend_data_reg[23:16], pend_data_reg[31:24]};
		end
	end

	// Boot read is armed once per reset and disarmed by the end of its frame
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			boot_armed_reg <= BOOT_CFG_INIT[`BOOT_EN_BIT];
		end else if (fresh_end && boot_armed_reg) begin
			boot_armed_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			nv_pattern_reg <= 8'h00;
		end else if (update_done && state_reg == flash_cmd_pkg::ST_PATTERN_PROG && !update_fail[0]) begin
			nv_pattern_reg <= pend_data_reg[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			vol_pattern_reg <= 8'h00;
		end else if (do_vol_write) begin
			vol_pattern_reg <= frame.data[7:0];
		end
	end

	always_comb begin
		status_reg_one = 8'h00;
		status_reg_one[`SR1_WIP_BIT] = write_in_progress;
		status_reg_one[`SR1_WEL_BIT] = wel_reg;
		status_reg_one[`SR1_E_FAIL_BIT] = e_fail_reg;
		status_reg_one[`SR1_P_FAIL_BIT] = p_fail_reg;
	end

	assign boot_read_config = boot_cfg_reg;
	assign nv_pattern = nv_pattern_reg;
	assign vol_pattern = vol_pattern_reg;

	default clocking sys_cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	sequence s_update_start;
		(state_reg == flash_cmd_pkg::ST_IDLE) ##1 (state_reg != flash_cmd_pkg::ST_IDLE);
	endsequence

	sequence s_update_end;
		(state_reg != flash_cmd_pkg::ST_IDLE) ##1 (state_reg == flash_cmd_pkg::ST_IDLE);
	endsequence

	a_latch_clear_done: assert property (
		(cmd_end && frame.instr == `INSTR_LATCH_CLEAR && frame.bits == `BITS_INSTR_ONLY && !write_in_progress) |=> !wel_reg)
		else $error("write enable latch not cleared");
	a_latch_clear_busy: assert property (
		(cmd_end && frame.instr == `INSTR_LATCH_CLEAR && write_in_progress && wel_reg && !update_done) |=> wel_reg)
		else $error("latch cleared while busy");
	a_latch_clear_count: assert property (
		(cmd_end && frame.instr == `INSTR_LATCH_CLEAR && frame.bits != `BITS_INSTR_ONLY
		&& wel_reg && !update_done) |=> wel_reg)
		else $error("latch cleared by a frame of wrong length");
	a_status_clear: assert property (
		(do_clr_status && state_reg == flash_cmd_pkg::ST_IDLE) |=> !e_fail_reg && !p_fail_reg && !write_in_progress)
		else $error("fail flags not cleared");
	a_status_keeps_latch: assert property (
		(do_clr_status && !update_done) |=> wel_reg == $past(wel_reg))
		else $error("clear status changed the latch");
	a_status_busy_accepted: assert property (
		(cmd_end && frame.instr == `INSTR_CLEAR_STATUS && frame.bits == `BITS_INSTR_ONLY
		&& p_fail_reg && state_reg == flash_cmd_pkg::ST_IDLE) |=> !p_fail_reg)
		else $error("clear status refused while busy");
	a_boot_write_start: assert property (
		do_boot_write |=> state_reg == flash_cmd_pkg::ST_BOOT_UPDATE && write_in_progress && wel_reg)
		else $error("boot register update not started");
	a_update_busy: assert property (
		s_update_start |-> status_reg_one[`SR1_WIP_BIT] [*8])
		else $error("write in progress not shown");
	a_update_end_latch: assert property (
		s_update_end |-> !wel_reg || $past(do_wel_set))
		else $error("latch not cleared at update end");
	a_write_discard: assert property (
		(cmd_end && !wel_reg && (frame.instr == `INSTR_BOOT_REG_WRITE || frame.instr == `INSTR_NV_PATTERN
		|| frame.instr == `INSTR_VOL_PATTERN) && state_reg == flash_cmd_pkg::ST_IDLE)
		|=> state_reg == flash_cmd_pkg::ST_IDLE && $stable(vol_pattern_reg) && $stable(boot_cfg_reg))
		else $error("write instruction taken without latch");
	a_vol_load: assert property (
		do_vol_write |=> vol_pattern_reg == $past(frame.data[7:0]) && state_reg == flash_cmd_pkg::ST_IDLE)
		else $error("volatile pattern not loaded at once");
	a_boot_once: assert property (
		(fresh_end && boot_armed_reg) |=> !boot_armed_reg ##1 !boot_armed_reg)
		else $error("boot read not disarmed");
	a_boot_delay_hold: assert property (
		@(posedge link_sck) disable iff (srst)
		(boot_armed_reg && !cs_n && bit_cur != 6'h3F
		&& {2'h0, bit_cur} < boot_cfg_reg[`BOOT_DELAY_MSB:`BOOT_DELAY_LSB]) |-> dq_oe == 4'h0)
		else $error("boot data driven during start delay");
	a_ecc_dummy_then_data: assert property (
		@(posedge link_sck) disable iff (srst || cs_n)
		(!boot_armed_reg && instr_reg == `INSTR_ECC_READ && bit_cur == `BITS_FOUR_BYTES && frame_on_reg)
		|-> dq_oe == 4'h0 ##8 dq_oe == 4'h2)
		else $error("ECC status not after eight dummy clocks");
	a_ecc_unit_hold: assert property (
		@(posedge link_sck) disable iff (srst || cs_n)
		(in_data && instr_reg == `INSTR_ECC_READ && !boot_armed_reg && dat_cur[6:0] != 7'h00)
		|-> ecc_unit_addr == $past(ecc_unit_addr))
		else $error("ECC unit changed within sixteen bytes");
	a_boot_reg_repeat: assert property (
		@(posedge link_sck) disable iff (srst || cs_n)
		(in_data && instr_reg == `INSTR_BOOT_REG_READ && !boot_armed_reg && dat_cur >= 24'h000020)
		|-> dq_out[1] == $past(dq_out[1], 32))
		else $error("boot register read does not repeat every 32 clocks");

endmodule // flash_register_command_unit

// file: verif/spi_host_model.sv
/*
 * Host side of the serial link: sends framed instructions and collects
 * read bits, serial or four bits per clock.
 * Assumes SPI mode 0 and a device that drives dq_out under dq_oe.
 */
`timescale 1ns/1ps
module spi_host_model (
	output logic link_sck,
	output logic cs_n,
	output wire logic [3:0] dq_in,
	input wire logic [3:0] dq_out,
	input wire logic [3:0] dq_oe
);
	logic [3:0] host_val;
	logic [255:0] rd_bits;

	// Pin level resolved from both drivers; released host bits keep toggling
	assign dq_in = (dq_oe & dq_out) | (~dq_oe & host_val);

	initial begin
		link_sck = 1'b0;
		cs_n = 1'b0;
		host_val = 4'hA;
		rd_bits = '0;
		// A definite rising edge after time zero clears the device's frame flag
		#1 cs_n = 1'b1;
	end

	// Clock of 125 ns keeps every command and boot read within its rated rate
	task automatic frame(input logic [7:0] ins, input logic [31:0] dat, input int nb, input int nr,
		input bit quad);
		int j;
		cs_n = 1'b0;
		for (int i = 0; i < nb + nr; i++) begin
			j = i - 8;
			if (i >= nb) begin
				host_val = ~host_val;
			end else if (i < 8) begin
				host_val = {~host_val[3:1], ins[7 - i]};
			end else begin
				host_val = {~host_val[3:1], (j < 32) ? dat[8 * (j / 8) + 7 - (j % 8)] : 1'b0};
			end
			// Read bits are taken mid low phase, where the value launched by the last rise is settled
			#31.25;
			if (i >= nb) begin
				rd_bits = quad ? {rd_bits[251:0], dq_in} : {rd_bits[254:0], dq_in[1]};
			end
			#31.25 link_sck = 1'b1;
			#62.5 link_sck = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		host_val = ~host_val;
		#300;
	endtask
endmodule // spi_host_model

// file: verif/tb.sv
/*
 * Self-checking bench of the register command unit: serial boot read,
 * table of register commands, failing update, register and ECC reads, then quad boot read.
 * Assumes the host model above and behavioural array and ECC answers.
 */
`timescale 1ns/1ps
module tb;
	typedef struct packed {
		logic [7:0] ins;
		logic [31:0] dat;
		logic [7:0] nb;
		logic [7:0] sr;
		logic [7:0] vol;
		logic [7:0] nv;
		logic [31:0] boot;
	} row_type;

	localparam logic [31:0] boot_init = 32'h0000_0205;

	logic sys_clk;
	logic srst;
	logic link_sck;
	logic cs_n;
	logic [3:0] dq_in;
	logic [3:0] dq_out;
	logic [3:0] dq_oe;
	logic [7:0] config_reg_one;
	logic [31:0] array_addr;
	logic [7:0] array_data;
	logic [31:0] ecc_unit_addr;
	logic [7:0] ecc_status;
	logic [1:0] update_fail;
	logic [7:0] status_reg_one;
	logic [31:0] boot_read_config;
	logic [7:0] nv_pattern;
	logic [7:0] vol_pattern;
	int n_mismatch;
	int cmp_count;
	row_type rows [12];

	assign array_data = array_addr[7:0] + array_addr[15:8];
	assign ecc_status = ecc_unit_addr[11:4];

	flash_register_command_unit #(.UPDATE_CYCLES(200), .BOOT_CFG_INIT(boot_init)) dut (
		.sys_clk(sys_clk), .srst(srst), .link_sck(link_sck), .cs_n(cs_n), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .config_reg_one(config_reg_one), .array_addr(array_addr),
		.array_data(array_data), .ecc_unit_addr(ecc_unit_addr), .ecc_status(ecc_status),
		.update_fail(update_fail), .status_reg_one(status_reg_one), .boot_read_config(boot_read_config),
		.nv_pattern(nv_pattern), .vol_pattern(vol_pattern)
	);

	spi_host_model host (.link_sck(link_sck), .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

	always #25 sys_clk = ~sys_clk;

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			n_mismatch++;
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wait_idle;
		int k;
		k = 0;
		while (status_reg_one[0] !== 1'b0 && k < 2000) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		if (k >= 2000) begin
			$display("MISMATCH wait_idle expected 0 seen 1");
			n_mismatch++;
			test_done();
		end
	endtask

	task automatic do_reset(input logic [7:0] cfg);
		@(posedge sys_clk);
		#1 srst = 1'b1;
		config_reg_one = cfg;
		repeat (2) @(posedge sys_clk);
		#1 srst = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	initial begin
		#3_000_000;
		$display("MISMATCH watchdog expected end seen hang");
		n_mismatch++;
		test_done();
	end

	initial begin
		sys_clk = 1'b0;
		// Reset starts low so that do_reset gives the link side a clean rising edge
		srst = 1'b0;
		config_reg_one = 8'h00;
		update_fail = 2'b00;
		n_mismatch = 0;
		cmp_count = 0;
		rows = '{
			'{8'h06, 32'h0, 8'h08, 8'h02, 8'h00, 8'h00, boot_init},
			'{8'h04, 32'h0, 8'h08, 8'h00, 8'h00, 8'h00, boot_init},
			'{8'h4A, 32'h5A, 8'h10, 8'h00, 8'h00, 8'h00, boot_init},
			'{8'h06, 32'h0, 8'h08, 8'h02, 8'h00, 8'h00, boot_init},
			'{8'h04, 32'h0, 8'h09, 8'h02, 8'h00, 8'h00, boot_init},
			'{8'h30, 32'h0, 8'h08, 8'h02, 8'h00, 8'h00, boot_init},
			'{8'h4A, 32'h5A, 8'h10, 8'h02, 8'h5A, 8'h00, boot_init},
			'{8'h43, 32'h3C, 8'h10, 8'h00, 8'h5A, 8'h3C, boot_init},
			'{8'h15, 32'h1234_5600, 8'h28, 8'h00, 8'h5A, 8'h3C, boot_init},
			'{8'h06, 32'h0, 8'h08, 8'h02, 8'h5A, 8'h3C, boot_init},
			'{8'h15, 32'h1234_5600, 8'h27, 8'h02, 8'h5A, 8'h3C, boot_init},
			'{8'h15, 32'h1234_5600, 8'h28, 8'h00, 8'h5A, 8'h3C, 32'h1234_5600}
		};
		do_reset(8'h00);
		chk("reset_status", 32'h0, 32'(status_reg_one));
		chk("reset_boot_cfg", boot_init, boot_read_config);
		chk("reset_patterns", 32'h0, {16'h0, nv_pattern, vol_pattern});
		chk("reset_oe", 32'h0, 32'(dq_oe));
		// Start address 1 block, delay 2: two idle clocks, then bytes of 200h and 201h
		host.frame(8'h00, 32'h0, 0, 18, 1'b0);
		chk("boot_serial", 32'h0203, 32'(host.rd_bits[15:0]));
		chk("oe_after_boot", 32'h0, 32'(dq_oe));
		$display("test boot_serial done");
		for (int r = 0; r < 12; r++) begin
			host.frame(rows[r].ins, rows[r].dat, int'(rows[r].nb), 0, 1'b0);
			wait_idle();
			chk("row_status", 32'(rows[r].sr), 32'(status_reg_one));
			chk("row_vol", 32'(rows[r].vol), 32'(vol_pattern));
			chk("row_nv", 32'(rows[r].nv), 32'(nv_pattern));
			chk("row_boot_cfg", rows[r].boot, boot_read_config);
		end
		$display("test command_table done");
		host.frame(8'h06, 32'h0, 8, 0, 1'b0);
		@(posedge sys_clk);
		#1 update_fail = 2'b11;
		host.frame(8'h15, 32'hFFFF_FF00, 40, 0, 1'b0);
		chk("update_busy", 32'h1, 32'(status_reg_one[0]));
		host.frame(8'h04, 32'h0, 8, 0, 1'b0);
		chk("latch_kept_busy", 32'h1, 32'(status_reg_one[1]));
		// Flags may keep the device busy, so wait the update time rather than for idle
		repeat (250) @(posedge sys_clk);
		#1;
		chk("fail_flags", 32'h60, 32'(status_reg_one & 8'h7E));
		chk("failed_boot_cfg", 32'h1234_5600, boot_read_config);
		@(posedge sys_clk);
		#1 update_fail = 2'b00;
		host.frame(8'h30, 32'h0, 8, 0, 1'b0);
		wait_idle();
		chk("flags_cleared", 32'h0, 32'(status_reg_one));
		$display("test failed_update done");
		host.frame(8'h14, 32'h0, 8, 64, 1'b0);
		chk("boot_reg_read", 32'h0056_3412, host.rd_bits[63:32]);
		chk("boot_reg_repeat", 32'h0056_3412, host.rd_bits[31:0]);
		host.frame(8'h18, 32'h2020_2020, 48, 136, 1'b0);
		chk("ecc_first", 32'h02, 32'(host.rd_bits[135:128]));
		chk("ecc_16th", 32'h02, 32'(host.rd_bits[15:8]));
		chk("ecc_next_unit", 32'h03, 32'(host.rd_bits[7:0]));
		$display("test register_reads done");
		do_reset(8'h02);
		chk("reload_boot_cfg", boot_init, boot_read_config);
		host.frame(8'h00, 32'h0, 0, 6, 1'b1);
		chk("boot_quad", 32'h0203, 32'(host.rd_bits[15:0]));
		$display("test boot_quad done");
		test_done();
	end
endmodule // tb
